// *** hw/chopper_defines.svh ***
`ifndef CHOPPER_DEFINES_SVH
`define CHOPPER_DEFINES_SVH

// Datagram address field and the code that selects the chopper word
`define CHOP_ADDR_HI 19
`define CHOP_ADDR_LO 17
`define CHOP_ADDR_CODE 3'h4

// Field positions inside the 20-bit datagram
`define CHOP_BLANK_HI 16
`define CHOP_BLANK_LO 15
`define CHOP_MODE_BIT 14
`define CHOP_RAND_BIT 13
`define CHOP_DEC_HI 12
`define CHOP_DEC_LO 11
`define CHOP_END_HI 10
`define CHOP_END_LO 7
`define CHOP_START_HI 6
`define CHOP_START_LO 4
`define CHOP_SLOW_HI 3
`define CHOP_SLOW_LO 0

// Reset value of the stored seventeen field bits: driver disabled
`define CHOP_CFG_RESET 17'h00000

// Timing figures in system clocks, plus step shifts, end-value bias and LFSR seed
`define CHOP_BLANK_0 6'h10
`define CHOP_BLANK_1 6'h18
`define CHOP_BLANK_2 6'h24
`define CHOP_BLANK_3 6'h36
`define CHOP_SLOW_BASE 9'h018
`define CHOP_SLOW_STEP_SH 5
`define CHOP_FAST_STEP_SH 5
`define CHOP_DEC_STEP 7'h10
`define CHOP_END_BIAS 6'h03
`define CHOP_LFSR_SEED 8'h01

`endif

// *** hw/chopper_pkg.sv ***
package chopper_pkg;

  // Bridge phase of the chopper cycle
  typedef enum logic [1:0] {PH_OFF, PH_ON, PH_FAST, PH_SLOW} phase_e;

endpackage

// *** hw/chopper_timing_config.sv ***
// Overview of operation
// - Blanking lasts 16, 24, 36 or 54 clocks per blank_time_sel.
// - chop_mode_sel picks hysteresis chopper (0) or constant off time with fast decay (1).
// - Constant off-time mode places fast decay right after the on phase.
// - Fast decay may end when coil current reaches negative nominal current.
// - rand_offtime_en adds a random 0 to 3 clocks to slow decay.
// - Hysteresis decrement period is 16, 32, 48 or 64 clocks.
// - Upper fast-control bit 0 lets comparator end fast decay; 1 means timer only.
// - Fast decay lasts 32 times the 4-bit fast setting, in clocks.
// - Hysteresis end code 0..15 maps to -3..12, in 1/512 steps.
// - Constant off-time mode outputs sine offset -3..12 added to table magnitude.
// - Hysteresis start lies code plus one, 1..8, above the end value.
// - Nonzero slow_decay_time gives slow decay of 24 plus 32 times it clocks.
// - Zero slow_decay_time disables the driver, all bridge switches off.
`timescale 1ns/10ps
`include "chopper_defines.svh"

module chopper_timing_config
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [19:0] cfg_word,
  input wire logic cfg_write,
  input wire logic coil_peak_in,
  input wire logic coil_neg_in,
  output logic drive_en,
  output logic bridge_on,
  output logic fast_decay,
  output logic slow_decay,
  output logic blanking,
  output logic signed [5:0] hyst_level,
  output logic signed [5:0] sine_offset
);

  // Blanking length for a 2-bit code
  function automatic logic [5:0] blank_cycles(input logic [1:0] code);
    case (code)
      2'h0: blank_cycles = `CHOP_BLANK_0;
      2'h1: blank_cycles = `CHOP_BLANK_1;
      2'h2: blank_cycles = `CHOP_BLANK_2;
      default: blank_cycles = `CHOP_BLANK_3;
    endcase
  endfunction

  logic [16:0] cfg_q;
  logic [2:0] peak_sync_q;
  logic [2:0] neg_sync_q;
  logic peak_q;
  logic neg_q;
  chopper_pkg::phase_e state_q;
  chopper_pkg::phase_e state_d;
  logic [8:0] timer_q;
  logic [8:0] timer_d;
  logic [5:0] blank_q;
  logic [6:0] dec_q;
  logic signed [5:0] hyst_q;
  logic [7:0] lfsr_q;

  // Field decode of the stored word
  wire logic [1:0] blank_sel = cfg_q[`CHOP_BLANK_HI:`CHOP_BLANK_LO];
  wire logic mode_cot = cfg_q[`CHOP_MODE_BIT];
  wire logic rand_en = cfg_q[`CHOP_RAND_BIT];
  wire logic [1:0] dec_ctl = cfg_q[`CHOP_DEC_HI:`CHOP_DEC_LO];
  wire logic [3:0] end_code = cfg_q[`CHOP_END_HI:`CHOP_END_LO];
  wire logic [2:0] start_code = cfg_q[`CHOP_START_HI:`CHOP_START_LO];
  wire logic [3:0] slow_code = cfg_q[`CHOP_SLOW_HI:`CHOP_SLOW_LO];

  wire logic cfg_hit = cfg_write && (cfg_word[`CHOP_ADDR_HI:`CHOP_ADDR_LO] == `CHOP_ADDR_CODE);

  // driver shut-off
  // Parks the phase machine too, so a later write restarts cleanly from the on phase
  wire logic slow_zero = (slow_code == 4'h0);

  wire logic [3:0] fast_set = {dec_ctl[0], start_code};
  wire logic [8:0] fast_len = {fast_set, 5'h00};

  // slow decay length; random extension from the LFSR
  wire logic [1:0] rnd_add = rand_en ? lfsr_q[1:0] : 2'h0;
  wire logic [8:0] slow_len = `CHOP_SLOW_BASE + 9'({slow_code, 5'h00}) + 9'(rnd_add);

  wire logic blank_active = (blank_q != 6'h00);
  wire logic peak_hit = peak_q && !blank_active;
  wire logic neg_hit = neg_q && !blank_active;
  wire logic timer_done = (timer_q == 9'h000);

  // comparator may end fast decay only with upper bit clear
  wire logic fast_end = timer_done || (neg_hit && !dec_ctl[1]);

  // end value biased down by three
  wire logic signed [5:0] hyst_end = $signed({2'h0, end_code}) - $signed(`CHOP_END_BIAS);
  // start sits code plus one above the end; host keeps the sum in range
  wire logic signed [5:0] hyst_start = hyst_end + $signed({3'h0, start_code}) + 6'sh01;
  // decrement period 16 times code plus one
  wire logic [6:0] dec_period = `CHOP_DEC_STEP * 7'({5'h00, dec_ctl} + 7'h01);
  wire logic switch_evt = (state_d != state_q);

  // Phase sequencing
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      chopper_pkg::PH_OFF: state_d = chopper_pkg::PH_ON;
      chopper_pkg::PH_ON:
        // mode select; fast decay right after on time
        if (peak_hit)
          state_d = (mode_cot && fast_set != 4'h0) ? chopper_pkg::PH_FAST : chopper_pkg::PH_SLOW;
      chopper_pkg::PH_FAST:
        // negative current or timer ends fast decay
        if (fast_end)
          state_d = chopper_pkg::PH_SLOW;
      chopper_pkg::PH_SLOW:
        if (timer_done)
          state_d = chopper_pkg::PH_ON;
      default: state_d = chopper_pkg::PH_OFF;
    endcase
    // zero off time forces the bridge off
    if (slow_zero)
      state_d = chopper_pkg::PH_OFF;
  end

  // Phase timer loads length minus one on entry to fast or slow decay
  always_comb
  begin
    timer_d = (timer_q == 9'h000) ? 9'h000 : timer_q - 9'h001;
    if (switch_evt && state_d == chopper_pkg::PH_FAST)
      timer_d = fast_len - 9'h001;
    else if (switch_evt && state_d == chopper_pkg::PH_SLOW)
      timer_d = slow_len - 9'h001;
  end

  // Configuration word storage
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      cfg_q <= `CHOP_CFG_RESET;
    else if (cfg_hit)
      cfg_q <= cfg_word[16:0];
  end

  // Comparator pins: three stages, accept when last two agree
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      peak_sync_q <= 3'h0;
      neg_sync_q <= 3'h0;
      peak_q <= 1'b0;
      neg_q <= 1'b0;
    end
    else
    begin
      peak_sync_q <= {peak_sync_q[1:0], coil_peak_in};
      neg_sync_q <= {neg_sync_q[1:0], coil_neg_in};
      if (peak_sync_q[1] == peak_sync_q[2])
        peak_q <= peak_sync_q[2];
      if (neg_sync_q[1] == neg_sync_q[2])
        neg_q <= neg_sync_q[2];
    end
  end

  // Phase state, timer and blanking
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= chopper_pkg::PH_OFF;
      timer_q <= 9'h000;
      blank_q <= 6'h00;
    end
    else
    begin
      state_q <= state_d;
      timer_q <= timer_d;
      // blanking restarts on every switching event
      if (switch_evt)
        blank_q <= blank_cycles(blank_sel);
      else if (blank_active)
        blank_q <= blank_q - 6'h01;
    end
  end

  // Random source; free running so the extension is not tied to the phase
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      lfsr_q <= `CHOP_LFSR_SEED;
    else
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end

  // Hysteresis walks from start down to end each chopper cycle
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hyst_q <= 6'sh00;
      dec_q <= 7'h00;
    end
    else if (switch_evt && state_d == chopper_pkg::PH_ON)
    begin
      hyst_q <= hyst_start;
      dec_q <= 7'h00;
    end
    else if (dec_q >= dec_period - 7'h01)
    begin
      dec_q <= 7'h00;
      if (hyst_q > hyst_end)
        hyst_q <= hyst_q - 6'sh01;
    end
    else
      dec_q <= dec_q + 7'h01;
  end

  // Outputs
  assign drive_en = (state_q != chopper_pkg::PH_OFF);
  assign bridge_on = (state_q == chopper_pkg::PH_ON);
  assign fast_decay = (state_q == chopper_pkg::PH_FAST);
  assign slow_decay = (state_q == chopper_pkg::PH_SLOW);
  assign blanking = blank_active;
  // hysteresis only in hysteresis chopper mode
  assign hyst_level = mode_cot ? 6'sh00 : hyst_q;
  // sine offset only in constant off-time mode
  assign sine_offset = mode_cot ? hyst_end : 6'sh00;

  // Checks on the design's own behaviour
  // Phase entries; loaded lengths are held against the word stored before the entry edge,
  // since a write landing on that edge only takes effect for the next phase
  sequence enter_slow_s;
    slow_decay && !$past(slow_decay);
  endsequence

  sequence enter_fast_s;
    fast_decay && !$past(fast_decay);
  endsequence

  sequence enter_on_s;
    bridge_on && !$past(bridge_on);
  endsequence

  a_cfg_update_word: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_hit |=> cfg_q == $past(cfg_word[16:0]))
    else $error("chopper word not updated");
  a_blank_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
    switch_evt |=> blank_q == blank_cycles($past(blank_sel)))
    else $error("blanking length wrong");
  a_hyst_no_fast: assert property (@(posedge sys_clk) disable iff (!nrst)
    bridge_on && !mode_cot |=> !fast_decay)
    else $error("fast decay in hysteresis mode");
  a_fast_after_on: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(fast_decay) |-> $past(bridge_on) && $past(mode_cot))
    else $error("fast decay not after on phase");
  a_neg_ends_fast: assert property (@(posedge sys_clk) disable iff (!nrst)
    fast_decay && neg_hit && !dec_ctl[1] && !slow_zero |=> slow_decay)
    else $error("negative current did not end fast decay");
  a_rand_off_fixed: assert property (@(posedge sys_clk) disable iff (!nrst)
    enter_slow_s ##0 !$past(rand_en) |-> timer_q == `CHOP_SLOW_BASE + 9'({$past(slow_code), 5'h00}) - 9'h001)
    else $error("fixed slow decay length wrong");

  // Hysteresis only ever steps down by one between reloads
  a_dec_one_step: assert property (@(posedge sys_clk) disable iff (!nrst)
    !mode_cot && !$past(mode_cot) && !$rose(bridge_on) && hyst_level < $past(hyst_level) |-> hyst_level == $past(hyst_level) - 6'sh01)
    else $error("hysteresis step not one");
  a_timer_only_fast: assert property (@(posedge sys_clk) disable iff (!nrst)
    fast_decay && dec_ctl[1] && !timer_done && !slow_zero && !cfg_hit |=> fast_decay)
    else $error("fast decay ended before timer");
  a_fast_load_len: assert property (@(posedge sys_clk) disable iff (!nrst)
    enter_fast_s |-> timer_q == {$past(dec_ctl[0]), $past(start_code), 5'h00} - 9'h001)
    else $error("fast decay length wrong");
  a_fast_timer_end: assert property (@(posedge sys_clk) disable iff (!nrst)
    fast_decay && timer_done && !slow_zero |=> slow_decay)
    else $error("fast decay outlived its timer");
  a_sine_offset_map: assert property (@(posedge sys_clk) disable iff (!nrst)
    mode_cot |-> sine_offset + 6'sh03 == $signed({2'h0, end_code}))
    else $error("sine offset mapping wrong");
  a_hyst_start_load: assert property (@(posedge sys_clk) disable iff (!nrst)
    enter_on_s |-> hyst_q == $signed({2'h0, $past(end_code)}) + $signed({3'h0, $past(start_code)}) - 6'sh02)
    else $error("hysteresis start wrong");

  // Slow decay length allows for the random extension of up to three clocks
  a_slow_load_len: assert property (@(posedge sys_clk) disable iff (!nrst)
    enter_slow_s |-> timer_q >= `CHOP_SLOW_BASE + 9'({$past(slow_code), 5'h00}) - 9'h001
      && timer_q <= `CHOP_SLOW_BASE + 9'({$past(slow_code), 5'h00}) + 9'h002)
    else $error("slow decay length out of range");
  a_slow_then_on: assert property (@(posedge sys_clk) disable iff (!nrst)
    slow_decay && timer_done && !slow_zero |=> bridge_on)
    else $error("slow decay did not end into on phase");
  a_off_when_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    slow_zero |=> !drive_en ##1 (!drive_en || !slow_zero))
    else $error("driver not disabled");
  a_blank_masks_peak: assert property (@(posedge sys_clk) disable iff (!nrst)
    bridge_on && blank_active && !slow_zero |=> bridge_on)
    else $error("comparator acted during blanking");
  a_blank_masks_neg: assert property (@(posedge sys_clk) disable iff (!nrst)
    fast_decay && blank_active && !timer_done && !slow_zero |=> fast_decay)
    else $error("negative comparator acted during blanking");

endmodule

// *** sim/coil_model.sv ***
`timescale 1ns/10ps
module coil_model
(
  input wire logic sys_clk,
  input wire logic bridge_on,
  input wire logic fast_decay,
  input wire logic [7:0] peak_dly,
  input wire logic [7:0] neg_dly,
  output logic coil_peak_in,
  output logic coil_neg_in
);
  // Known start values so the comparators never show an unknown level
  logic [1:0] ph_q = 2'h0;
  logic [7:0] age_q = 8'h00;

  // Age of the current bridge phase, saturating so a long phase never wraps
  always_ff @(posedge sys_clk)
  begin
    ph_q <= {bridge_on, fast_decay};
    age_q <= ({bridge_on, fast_decay} != ph_q) ? 8'h00 : ((age_q < 8'hFE) ? age_q + 8'h01 : age_q);
  end

  // Comparators trip after a set delay; 8'hFF means the current never gets there
  assign coil_peak_in = bridge_on && (peak_dly != 8'hFF) && (age_q >= peak_dly);
  assign coil_neg_in = fast_decay && (neg_dly != 8'hFF) && (age_q >= neg_dly);
endmodule

// *** sim/chopper_timing_config_tb_top.sv ***
`timescale 1ns/10ps
module chopper_timing_config_tb_top;
  logic sys_clk, nrst, cfg_write, coil_peak_in, coil_neg_in;
  logic drive_en, bridge_on, fast_decay, slow_decay, blanking;
  logic [19:0] cfg_word;
  logic signed [5:0] hyst_level, sine_offset;
  logic [7:0] peak_dly, neg_dly;
  int error_cnt, num_checks, len, k, seen_long;
  int blank_tab[4] = '{16, 24, 36, 54};

  chopper_timing_config uut (.sys_clk(sys_clk), .nrst(nrst), .cfg_word(cfg_word), .cfg_write(cfg_write),
    .coil_peak_in(coil_peak_in), .coil_neg_in(coil_neg_in), .drive_en(drive_en), .bridge_on(bridge_on),
    .fast_decay(fast_decay), .slow_decay(slow_decay), .blanking(blanking), .hyst_level(hyst_level),
    .sine_offset(sine_offset));
  coil_model coil (.sys_clk(sys_clk), .bridge_on(bridge_on), .fast_decay(fast_decay), .peak_dly(peak_dly),
    .neg_dly(neg_dly), .coil_peak_in(coil_peak_in), .coil_neg_in(coil_neg_in));

  // Free-running system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [19:0] chop(input int bsel, mode, rnd, dctl, ecode, scode, slow);
    return {3'h4, 2'(bsel), 1'(mode), 1'(rnd), 2'(dctl), 4'(ecode), 3'(scode), 4'(slow)};
  endfunction

  function automatic logic ph(input int s);
    return (s == 0) ? bridge_on : (s == 1) ? fast_decay : (s == 2) ? slow_decay : blanking;
  endfunction

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Datagram writes launch at the falling edge, one-cycle strobe
  task write_cfg(input logic [19:0] w);
    @(negedge sys_clk);
    cfg_word = w;
    cfg_write = 1'b1;
    @(negedge sys_clk);
    cfg_write = 1'b0;
  endtask

  // Fresh entry only: a run already under way is skipped, not measured
  task wait_rise(input int s);
    for (k = 0; k < 2000 && ph(s) === 1'b1; k++) @(negedge sys_clk);
    for (k = 0; k < 2000 && ph(s) !== 1'b1; k++) @(negedge sys_clk);
    if (k == 2000)
    begin
      error_cnt++;
      $display("wrong value timeout expected phase %0d seen none", s);
      print_verdict();
    end
  endtask

  task count_len(input int s, output int n);
    for (n = 0; n < 2000 && ph(s) === 1'b1; n++) @(negedge sys_clk);
  endtask

  task run_len(input int s, output int n);
    wait_rise(s);
    count_len(s, n);
  endtask

  initial
  begin
    nrst = 1'b0;
    cfg_write = 1'b0;
    cfg_word = 20'h00000;
    peak_dly = 8'h00;
    neg_dly = 8'hFF;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    check("drive_en_reset", 0, drive_en);
    // Other register addresses must leave the driver off
    for (int a = 0; a < 8; a++)
      if (a != 4) write_cfg({3'(a), 17'h00001});
    repeat (3) @(negedge sys_clk);
    check("drive_en_other_addr", 0, drive_en);
    $display("test addressing done");
    for (int t = 0; t < 4; t++)
    begin
      // Shortest blanking gets a longer off time
      write_cfg(chop(t, 0, 0, 0, 3, 0, (t == 0) ? 2 : 1));
      run_len(3, len);
      check("blank_len", blank_tab[t], len);
      run_len(0, len);
      check("on_outlasts_blank", 1, len > blank_tab[t]);
      run_len(2, len);
      check("slow_len", 24 + 32 * ((t == 0) ? 2 : 1), len);
    end
    $display("test blanking and off time done");
    peak_dly = 8'hC8;
    for (int d = 0; d < 4; d++)
    begin
      write_cfg(chop(3, 0, 0, d, 5, 2, 1));
      wait_rise(0);
      @(negedge sys_clk);
      check("hyst_start", 5, 32'(hyst_level));
      check("sine_in_hyst", 0, 32'(sine_offset));
      for (len = 1; len < 100 && hyst_level === 6'sh05; len++) @(negedge sys_clk);
      check("hyst_dec_period", 1, len >= 16 * (d + 1) - 3 && len <= 16 * (d + 1) + 3);
      repeat (50 * (d == 0)) @(negedge sys_clk);
      if (d == 0) check("hyst_end", 2, 32'(hyst_level));
    end
    $display("test hysteresis done");
    peak_dly = 8'h00;
    neg_dly = 8'h0A;
    for (int m = 0; m < 2; m++)
    begin
      write_cfg(chop(1, 1, 0, m ? 0 : 3, m ? 15 : 0, m ? 3 : 1, 2));
      run_len(0, len);
      check("fast_follows_on", 1, fast_decay);
      count_len(1, len);
      if (m == 0) check("fast_timer_only", 288, len);
      if (m == 1) check("fast_cut_by_neg", 1, len < 96);
      check("sine_offset", m ? 12 : -3, 32'(sine_offset));
      check("hyst_in_const", 0, 32'(hyst_level));
    end
    $display("test constant off time done");
    write_cfg(chop(1, 0, 1, 0, 3, 0, 1));
    seen_long = 0;
    for (int r = 0; r < 8; r++)
    begin
      run_len(2, len);
      check("slow_rand_range", 1, len >= 56 && len <= 59);
      if (len > 56) seen_long = 1;
    end
    check("slow_rand_varies", 1, seen_long);
    $display("test random off time done");
    write_cfg(chop(1, 0, 0, 0, 3, 0, 0));
    repeat (3) @(negedge sys_clk);
    check("bridges_off", 0, {drive_en, bridge_on, fast_decay, slow_decay});
    $display("test driver disable done");
    print_verdict();
  end
endmodule
